// >>> rph_map.svh
// Contract
// - on/off config write accepts only the pin-plus-operation mode; others flag a fault.
// - on/off config, capability and revision settings are fixed and not readable.
// - live status, such as output off, is refreshed every clock.
// - alarm bits stay set until a clear-faults command or an operation off-to-on.
// - clear-faults clears all alarms and the controlling port's alert.
// - clear-faults from the non-controlling port is accepted but clears nothing.
// - a persisting fault clears for one cycle, then sets again.
// - out-of-range writes keep the old value and set the comm fault flag.
// - each limit has its own default, low and high bound; setpoint 52, 41..56.
// - operation accepts only 0x80 on and 0x00 off; output on after reset.
// - write lock 00 all writes, 80 lock and clear-faults only, 40 lock, clear-faults and operation.
// - write lock never blocks reads or write lock writes.
// - write lock resets to all writes enabled, never stored.
// - restore-all reloads every limit from fixed defaults.
// - restore-one reloads only the named limit.
// - format register is read-only, linear mode, exponent minus nine.
// - voltage words are 16-bit mantissa times 2^-9, low byte first.
// - after a setpoint write the program pin is ignored until reset.
// - turn-on and turn-off thresholds are read-only and follow line setting.
// - overvoltage restarts after 1 s, third trip in window latches off.
// - fewer than three trips in 1 minute resets the count.
// - latch released by control pin off-on or operation off-on.
// - every transfer carries a good packet check; bad ones are refused.
// - 5 s without bus activity reinitialises the port; commands then may be missed.
// - port 0 holds control after reset.
`ifndef RPH_MAP_SVH
`define RPH_MAP_SVH

`define RPH_CMD_OPERATION 8'h01
`define RPH_CMD_ONOFF_CFG 8'h02
`define RPH_CMD_CLEAR 8'h03
`define RPH_CMD_WRITE_LOCK 8'h10
`define RPH_CMD_RESTORE_ALL 8'h12
`define RPH_CMD_RESTORE_ONE 8'h14
`define RPH_CMD_CAPABILITY 8'h19
`define RPH_CMD_VOUT_FORMAT 8'h20
`define RPH_CMD_VIN_ON 8'h35
`define RPH_CMD_VIN_OFF 8'h36
`define RPH_CMD_OV_RESPONSE 8'h41
`define RPH_CMD_STATUS_BYTE 8'h78
`define RPH_CMD_STATUS_WORD 8'h79
`define RPH_CMD_REVISION 8'h98

`define RPH_OP_ON 8'h80
`define RPH_OP_OFF 8'h00
`define RPH_OP_RESET 8'h80
`define RPH_WL_ALL 8'h00
`define RPH_WL_ONLY_LOCK 8'h80
`define RPH_WL_LOCK_OP 8'h40
`define RPH_WL_RESET 8'h00
`define RPH_ONOFF_CFG_VAL 8'h1e
`define RPH_VOUT_FORMAT_VAL 8'h17
`define RPH_OV_RESPONSE_VAL 8'h80
`define RPH_VIN_ON_HIGH 16'h0172
`define RPH_VIN_OFF_HIGH 16'h0154
`define RPH_VIN_ON_LOW 16'h00d2
`define RPH_VIN_OFF_LOW 16'h00b4

// limit table: code, default, low, high; voltage words in 2^-9 V, others in half units
`define RPH_LIM_N 14
`define RPH_LIM_VOUT_IDX 4'd0
`define RPH_LIM_00 {8'h21, 16'h6800, 16'h5200, 16'h7000}
`define RPH_LIM_01 {8'h40, 16'h6e00, 16'h5400, 16'h6e00}
`define RPH_LIM_02 {8'h42, 16'h6c00, 16'h5400, 16'h6e00}
`define RPH_LIM_03 {8'h43, 16'h5000, 16'h4e00, 16'h6e00}
`define RPH_LIM_04 {8'h44, 16'h4e00, 16'h4e00, 16'h6e00}
`define RPH_LIM_05 {8'h46, 16'h0098, 16'h0000, 16'h0098}
`define RPH_LIM_06 {8'h48, 16'h4e00, 16'h4e00, 16'h6e00}
`define RPH_LIM_07 {8'h4a, 16'h0097, 16'h0000, 16'h0097}
`define RPH_LIM_08 {8'h4f, 16'h00dc, 16'h0000, 16'h012c}
`define RPH_LIM_09 {8'h51, 16'h00d2, 16'h0000, 16'h012c}
`define RPH_LIM_10 {8'h55, 16'h0258, 16'h0172, 16'h021c}
`define RPH_LIM_11 {8'h57, 16'h024e, 16'h0172, 16'h0212}
`define RPH_LIM_12 {8'h58, 16'h0168, 16'h0168, 16'h0212}
`define RPH_LIM_13 {8'h59, 16'h015e, 16'h015e, 16'h0212}

`define RPH_OV_LATCH_TRIPS 2'd2
`define RPH_CLK_KHZ 25000
`define RPH_RESTART_MS 1000
`define RPH_WINDOW_MS 60000
`define RPH_IDLE_MS 5000
`define RPH_RESTART_CYC (`RPH_RESTART_MS * `RPH_CLK_KHZ)
`define RPH_WINDOW_CYC (`RPH_WINDOW_MS * `RPH_CLK_KHZ)
`define RPH_IDLE_CYC (`RPH_IDLE_MS * `RPH_CLK_KHZ)

`endif

// >>> rph_pkg.sv
package rph_pkg;
	typedef struct packed {
		logic [7:0] code;
		logic [15:0] dflt;
		logic [15:0] low;
		logic [15:0] high;
	} rph_lim_t;

	typedef enum logic [1:0] {
		OV_RUN,
		OV_WAIT,
		OV_LATCHED
	} rph_ov_state_t;

	typedef struct packed {
		logic [31:0] cnt;
		logic busy;
		logic expire;
	} rph_timer_state_t;

	typedef struct packed {
		logic op_on;
		logic [7:0] write_lock;
		logic ctl_port;
		logic [13:0][15:0] limits;
		logic digital_vout;
		logic alm_ov;
		logic alm_oc;
		logic alm_uv;
		logic alm_ot;
		logic alm_cml;
		rph_ov_state_t ov_state;
		logic [1:0] ov_count;
		logic pin_q;
		logic ov_q;
		logic [1:0] alert;
		logic rsp_valid;
		logic rsp_ack;
		logic [15:0] rsp_data;
		logic out_en;
		logic [15:0] vout_sp;
		logic reinit;
		logic latched;
	} rph_state_t;
endpackage : rph_pkg

// >>> rph_timer.sv
`timescale 1ns/10ps
module rph_timer (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// control
	input wire logic start_in,
	input wire logic [31:0] limit_in,
	// status
	output logic busy_out,
	output logic expire_out
);
	import rph_pkg::*;

	rph_timer_state_t s;
	rph_timer_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.expire = 1'b0;
		if (start_in) begin
			next_s.cnt = 32'h0000_0000;
			next_s.busy = 1'b1;
		end else if (s.busy) begin
			if (s.cnt >= limit_in - 32'h0000_0001) begin
				next_s.busy = 1'b0;
				next_s.expire = 1'b1;
			end else begin
				next_s.cnt = s.cnt + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign busy_out = s.busy;
	assign expire_out = s.expire;
endmodule : rph_timer

// >>> rph_command_handler.sv
`timescale 1ns/10ps
`include "rph_map.svh"
module rph_command_handler #(
	parameter int RESTART_CYC = `RPH_RESTART_CYC,
	parameter int WINDOW_CYC = `RPH_WINDOW_CYC,
	parameter int IDLE_CYC = `RPH_IDLE_CYC
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// decoded command from the two i2c ports
	input wire logic cmd_valid_in,
	input wire logic cmd_port_in,
	input wire logic cmd_write_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic [15:0] cmd_data_in,
	input wire logic cmd_pec_ok_in,
	input wire logic bus_activity_in,
	input wire logic control_port_in,
	// answer
	output logic rsp_valid_out,
	output logic rsp_ack_out,
	output logic [15:0] rsp_data_out,
	output logic [1:0] alert_out,
	output logic i2c_reinit_out,
	// power stage
	input wire logic output_control_pin_in,
	input wire logic high_line_setting_in,
	input wire logic [15:0] voltage_program_pin_in,
	input wire logic ov_fault_in,
	input wire logic oc_fault_in,
	input wire logic vin_uv_fault_in,
	input wire logic temp_fault_in,
	output logic output_enable_out,
	output logic [15:0] vout_setpoint_out,
	output logic digital_vout_out,
	output logic latched_off_out
);
	import rph_pkg::*;

	rph_state_t s;
	rph_state_t next_s;
	logic restart_busy;
	logic restart_exp;
	logic window_busy;
	logic window_exp;
	logic idle_busy;
	logic idle_exp;
	logic restart_start;
	logic window_start;
	logic idle_start;

	function automatic rph_lim_t lim_info(input logic [3:0] i);
		case (i)
			4'd0: lim_info = `RPH_LIM_00;
			4'd1: lim_info = `RPH_LIM_01;
			4'd2: lim_info = `RPH_LIM_02;
			4'd3: lim_info = `RPH_LIM_03;
			4'd4: lim_info = `RPH_LIM_04;
			4'd5: lim_info = `RPH_LIM_05;
			4'd6: lim_info = `RPH_LIM_06;
			4'd7: lim_info = `RPH_LIM_07;
			4'd8: lim_info = `RPH_LIM_08;
			4'd9: lim_info = `RPH_LIM_09;
			4'd10: lim_info = `RPH_LIM_10;
			4'd11: lim_info = `RPH_LIM_11;
			4'd12: lim_info = `RPH_LIM_12;
			4'd13: lim_info = `RPH_LIM_13;
			default: lim_info = '0;
		endcase
	endfunction : lim_info

	function automatic logic [15:0] lim_dflt(input logic [3:0] i);
		rph_lim_t e;
		e = lim_info(i);
		lim_dflt = e.dflt;
	endfunction : lim_dflt

	// returns {hit, index} of a limit command code
	function automatic logic [4:0] find_lim(input logic [7:0] code);
		rph_lim_t e;
		find_lim = 5'h00;
		for (int i = 0; i < `RPH_LIM_N; i++) begin
			e = lim_info(4'(i));
			if (e.code == code) begin
				find_lim = {1'b1, 4'(i)};
			end
		end
	endfunction : find_lim

	// sticky alarm: a clear drops it for one cycle, a persisting level sets it again
	function automatic logic sticky(input logic old, input logic lvl, input logic edge_ev, input logic clr);
		sticky = clr ? edge_ev : (old | lvl);
	endfunction : sticky

	rph_timer u_restart_timer (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.start_in(restart_start),
		.limit_in(RESTART_CYC),
		.busy_out(restart_busy),
		.expire_out(restart_exp)
	);

	rph_timer u_window_timer (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.start_in(window_start),
		.limit_in(WINDOW_CYC),
		.busy_out(window_busy),
		.expire_out(window_exp)
	);

	rph_timer u_idle_timer (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.start_in(idle_start),
		.limit_in(IDLE_CYC),
		.busy_out(idle_busy),
		.expire_out(idle_exp)
	);

	logic pin_rise;
	logic ov_rise;
	logic clr;
	logic cml_ev;
	logic op_restart;
	logic is_ctl;
	logic wl_block;
	logic [4:0] hit;
	logic [4:0] hit_data;
	rph_lim_t ent;
	logic [7:0] status_byte;
	logic [7:0] status_high;

	assign pin_rise = output_control_pin_in & ~s.pin_q;
	assign ov_rise = ov_fault_in & ~s.ov_q;
	assign restart_start = ov_rise && s.ov_state == OV_RUN && s.ov_count != `RPH_OV_LATCH_TRIPS;
	assign window_start = ov_rise && s.ov_state == OV_RUN && s.ov_count == 2'd0;
	assign idle_start = bus_activity_in | ~idle_busy;

	assign status_byte = {1'b0, ~s.out_en, s.alm_ov, s.alm_oc, s.alm_uv, s.alm_ot, s.alm_cml,
		~(s.alm_ov | s.alm_oc | s.alm_uv | s.alm_ot | s.alm_cml | ~s.out_en)};
	assign status_high = {s.alm_ov, s.alm_oc, s.alm_uv, 1'b0, ~s.out_en, 3'b000};

	always_comb begin
		next_s = s;
		next_s.rsp_valid = 1'b0;
		next_s.ctl_port = control_port_in;
		next_s.pin_q = output_control_pin_in;
		next_s.ov_q = ov_fault_in;
		clr = 1'b0;
		cml_ev = 1'b0;
		op_restart = 1'b0;
		is_ctl = cmd_port_in == s.ctl_port;
		hit = find_lim(cmd_code_in);
		hit_data = find_lim(cmd_data_in[7:0]);
		ent = lim_info(hit[3:0]);
		wl_block = (s.write_lock == `RPH_WL_ONLY_LOCK && cmd_code_in != `RPH_CMD_WRITE_LOCK) ||
			(s.write_lock == `RPH_WL_LOCK_OP && cmd_code_in != `RPH_CMD_WRITE_LOCK &&
			cmd_code_in != `RPH_CMD_OPERATION);
		if (cmd_valid_in && !idle_exp) begin
			next_s.rsp_valid = 1'b1;
			next_s.rsp_ack = 1'b1;
			next_s.rsp_data = 16'h0000;
			if (!cmd_pec_ok_in) begin
				next_s.rsp_ack = 1'b0;
				cml_ev = 1'b1;
			end else if (!cmd_write_in) begin
				case (cmd_code_in)
					`RPH_CMD_OPERATION: next_s.rsp_data = {8'h00, s.op_on ? `RPH_OP_ON : `RPH_OP_OFF};
					`RPH_CMD_WRITE_LOCK: next_s.rsp_data = {8'h00, s.write_lock};
					`RPH_CMD_VOUT_FORMAT: next_s.rsp_data = {8'h00, `RPH_VOUT_FORMAT_VAL};
					`RPH_CMD_OV_RESPONSE: next_s.rsp_data = {8'h00, `RPH_OV_RESPONSE_VAL};
					`RPH_CMD_VIN_ON: next_s.rsp_data = high_line_setting_in ? `RPH_VIN_ON_HIGH : `RPH_VIN_ON_LOW;
					`RPH_CMD_VIN_OFF: next_s.rsp_data = high_line_setting_in ? `RPH_VIN_OFF_HIGH : `RPH_VIN_OFF_LOW;
					`RPH_CMD_STATUS_BYTE: next_s.rsp_data = {8'h00, status_byte};
					`RPH_CMD_STATUS_WORD: next_s.rsp_data = {status_high, status_byte};
					default: begin
						if (hit[4]) begin
							next_s.rsp_data = s.limits[hit[3:0]];
						end else begin
							next_s.rsp_ack = 1'b0;
							cml_ev = 1'b1;
						end
					end
				endcase
			end else if (cmd_code_in == `RPH_CMD_CLEAR) begin
				clr = is_ctl;
			end else if (!is_ctl) begin
				next_s.rsp_ack = 1'b0;
			end else if (wl_block) begin
				next_s.rsp_ack = 1'b0;
				cml_ev = 1'b1;
			end else begin
				case (cmd_code_in)
					`RPH_CMD_OPERATION: begin
						if (cmd_data_in[7:0] == `RPH_OP_ON) begin
							op_restart = ~s.op_on;
							next_s.op_on = 1'b1;
						end else if (cmd_data_in[7:0] == `RPH_OP_OFF) begin
							next_s.op_on = 1'b0;
						end else begin
							cml_ev = 1'b1;
						end
					end
					`RPH_CMD_WRITE_LOCK: begin
						if (cmd_data_in[7:0] == `RPH_WL_ALL || cmd_data_in[7:0] == `RPH_WL_ONLY_LOCK ||
							cmd_data_in[7:0] == `RPH_WL_LOCK_OP) begin
							next_s.write_lock = cmd_data_in[7:0];
						end else begin
							cml_ev = 1'b1;
						end
					end
					`RPH_CMD_ONOFF_CFG: begin
						cml_ev = cmd_data_in[7:0] != `RPH_ONOFF_CFG_VAL;
					end
					`RPH_CMD_RESTORE_ALL: begin
						for (int i = 0; i < `RPH_LIM_N; i++) begin
							next_s.limits[i] = lim_dflt(4'(i));
						end
					end
					`RPH_CMD_RESTORE_ONE: begin
						if (hit_data[4]) begin
							next_s.limits[hit_data[3:0]] = lim_dflt(hit_data[3:0]);
						end else begin
							cml_ev = 1'b1;
						end
					end
					default: begin
						if (hit[4] && cmd_data_in >= ent.low && cmd_data_in <= ent.high) begin
							next_s.limits[hit[3:0]] = cmd_data_in;
							if (hit[3:0] == `RPH_LIM_VOUT_IDX) begin
								next_s.digital_vout = 1'b1;
							end
						end else begin
							cml_ev = 1'b1;
						end
					end
				endcase
			end
		end
		if (op_restart) begin
			clr = 1'b1;
		end
		next_s.alm_ov = sticky(s.alm_ov, ov_fault_in, ov_rise, clr);
		next_s.alm_oc = sticky(s.alm_oc, oc_fault_in, 1'b0, clr);
		next_s.alm_uv = sticky(s.alm_uv, vin_uv_fault_in, 1'b0, clr);
		next_s.alm_ot = sticky(s.alm_ot, temp_fault_in, 1'b0, clr);
		next_s.alm_cml = sticky(s.alm_cml, cml_ev, cml_ev, clr);
		if (window_exp && !ov_rise) begin
			next_s.ov_count = 2'd0;
		end
		case (s.ov_state)
			OV_RUN: begin
				if (ov_rise) begin
					if (s.ov_count == `RPH_OV_LATCH_TRIPS) begin
						next_s.ov_state = OV_LATCHED;
						next_s.ov_count = 2'd0;
					end else begin
						next_s.ov_state = OV_WAIT;
						next_s.ov_count = s.ov_count + 2'd1;
					end
				end
			end
			OV_WAIT: begin
				if (restart_exp) begin
					next_s.ov_state = OV_RUN;
				end
			end
			OV_LATCHED: begin
				if (pin_rise || op_restart) begin
					next_s.ov_state = OV_RUN;
					next_s.ov_count = 2'd0;
				end
			end
			default: next_s.ov_state = OV_RUN;
		endcase
		next_s.out_en = next_s.op_on & output_control_pin_in & (next_s.ov_state == OV_RUN);
		next_s.alert = 2'b00;
		next_s.alert[next_s.ctl_port] = next_s.alm_ov | next_s.alm_oc | next_s.alm_uv | next_s.alm_ot |
			next_s.alm_cml;
		next_s.vout_sp = s.digital_vout ? s.limits[`RPH_LIM_VOUT_IDX] : voltage_program_pin_in;
		next_s.reinit = idle_exp;
		next_s.latched = next_s.ov_state == OV_LATCHED;
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			s <= '0;
			s.op_on <= 1'b1;
			s.write_lock <= `RPH_WL_RESET;
			s.ctl_port <= 1'b0;
			s.ov_state <= OV_RUN;
			// pin idles high: no false rising edge after reset
			s.pin_q <= 1'b1;
			for (int i = 0; i < `RPH_LIM_N; i++) begin
				s.limits[i] <= lim_dflt(4'(i));
			end
		end else begin
			s <= next_s;
		end
	end

	assign rsp_valid_out = s.rsp_valid;
	assign rsp_ack_out = s.rsp_ack;
	assign rsp_data_out = s.rsp_data;
	assign alert_out = s.alert;
	assign i2c_reinit_out = s.reinit;
	assign output_enable_out = s.out_en;
	assign vout_setpoint_out = s.vout_sp;
	assign digital_vout_out = s.digital_vout;
	assign latched_off_out = s.latched;
endmodule : rph_command_handler

// >>> rph_command_handler_properties.sv
`timescale 1ns/10ps
module rph_command_handler_properties #(
	parameter int RESTART_CYC = 10,
	parameter int WINDOW_CYC = 200,
	parameter int IDLE_CYC = 50
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// command port
	input wire logic cmd_valid_in,
	input wire logic cmd_port_in,
	input wire logic cmd_write_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic [15:0] cmd_data_in,
	input wire logic cmd_pec_ok_in,
	input wire logic bus_activity_in,
	input wire logic control_port_in,
	// answer
	input wire logic rsp_valid_out,
	input wire logic rsp_ack_out,
	input wire logic [1:0] alert_out,
	input wire logic i2c_reinit_out,
	// power stage
	input wire logic output_control_pin_in,
	input wire logic output_enable_out,
	input wire logic [15:0] vout_setpoint_out,
	input wire logic digital_vout_out,
	input wire logic latched_off_out
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);
	sequence s_bad_pec;
		cmd_valid_in && !cmd_pec_ok_in && bus_activity_in && !control_port_in
			##1 (!cmd_valid_in && !control_port_in) [*2];
	endsequence
	sequence s_wr_ok(logic [7:0] code);
		cmd_valid_in && cmd_write_in && cmd_code_in == code && cmd_pec_ok_in && !cmd_port_in && !control_port_in
			##1 rsp_valid_out && rsp_ack_out;
	endsequence
	chk_lock_read_ok: assert property (cmd_valid_in && !cmd_write_in && cmd_code_in == 8'h10 && cmd_pec_ok_in
		|=> i2c_reinit_out || (rsp_valid_out && rsp_ack_out)) else $error("lock read not answered");
	chk_pec_refused: assert property (cmd_valid_in && !cmd_pec_ok_in
		|=> i2c_reinit_out || (rsp_valid_out && !rsp_ack_out)) else $error("bad packet check accepted");
	chk_fault_alert: assert property (s_bad_pec |-> ##[0:1] alert_out[0]) else $error("comm fault without alert");
	chk_alert_owner: assert property (!control_port_in && !$past(control_port_in) && !$past(control_port_in, 2)
		|-> !alert_out[1]) else $error("alert on idle port");
	chk_foreign_clear: assert property (cmd_valid_in && cmd_write_in && cmd_code_in == 8'h03 && cmd_port_in
		&& !control_port_in && !$past(control_port_in) && alert_out[0]
		|=> alert_out[0]) else $error("foreign clear dropped alert");
	chk_op_off: assert property (cmd_data_in[7:0] == 8'h00 ##0 s_wr_ok(8'h01)
		|-> ##[0:1] !output_enable_out) else $error("output stayed on");
	chk_vout_taken: assert property (cmd_data_in inside {[16'h5200:16'h7000]} ##0 s_wr_ok(8'h21)
		|=> vout_setpoint_out == $past(cmd_data_in, 2) && digital_vout_out) else $error("setpoint not taken");
	chk_range_keep: assert property (cmd_data_in > 16'h7000 ##0 s_wr_ok(8'h21) ##0 digital_vout_out
		|=> $stable(vout_setpoint_out) [*3]) else $error("out of range setpoint taken");
	chk_reinit_cause: assert property (i2c_reinit_out |-> !$past(bus_activity_in, 2) ##1 !i2c_reinit_out)
		else $error("reinit pulse wrong");
	chk_latch_dark: assert property (latched_off_out && $past(latched_off_out) |-> !output_enable_out)
		else $error("output on while latched");
	chk_power_up_on: assert property ($rose(rst_n_in) && output_control_pin_in |-> ##[0:2] output_enable_out)
		else $error("output off after reset");
endmodule : rph_command_handler_properties

bind rph_command_handler rph_command_handler_properties #(.RESTART_CYC(RESTART_CYC), .WINDOW_CYC(WINDOW_CYC),
	.IDLE_CYC(IDLE_CYC)) chk_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in),
	.cmd_port_in(cmd_port_in), .cmd_write_in(cmd_write_in), .cmd_code_in(cmd_code_in), .cmd_data_in(cmd_data_in),
	.cmd_pec_ok_in(cmd_pec_ok_in), .bus_activity_in(bus_activity_in), .control_port_in(control_port_in),
	.rsp_valid_out(rsp_valid_out), .rsp_ack_out(rsp_ack_out), .alert_out(alert_out), .i2c_reinit_out(i2c_reinit_out),
	.output_control_pin_in(output_control_pin_in), .output_enable_out(output_enable_out),
	.vout_setpoint_out(vout_setpoint_out), .digital_vout_out(digital_vout_out), .latched_off_out(latched_off_out));

// >>> rph_host_model.sv
`timescale 1ns/10ps
module rph_host_model (
	// clock
	input wire logic mclk_in,
	// answer
	input wire logic rsp_ack_in,
	input wire logic [15:0] rsp_data_in,
	// decoded command
	output logic cmd_valid_out,
	output logic cmd_port_out,
	output logic cmd_write_out,
	output logic [7:0] cmd_code_out,
	output logic [15:0] cmd_data_out,
	output logic cmd_pec_ok_out
);
	initial begin
		cmd_valid_out = 1'b0;
		cmd_port_out = 1'b0;
		cmd_write_out = 1'b0;
		cmd_code_out = 8'h00;
		cmd_data_out = 16'h0000;
		cmd_pec_ok_out = 1'b1;
	end
	// one transfer, then a quiet cycle; released code and data lines show the inverse of the last value
	task automatic xfer(input logic port, input logic wr, input logic [7:0] code, input logic [15:0] data,
		input logic pec, output logic ack, output logic [15:0] rd);
		@(negedge mclk_in);
		cmd_valid_out = 1'b1;
		cmd_port_out = port;
		cmd_write_out = wr;
		cmd_code_out = code;
		cmd_data_out = data;
		cmd_pec_ok_out = pec;
		@(negedge mclk_in);
		ack = rsp_ack_in;
		rd = rsp_data_in;
		cmd_valid_out = 1'b0;
		cmd_code_out = ~code;
		cmd_data_out = ~data;
		@(negedge mclk_in);
	endtask : xfer
endmodule : rph_host_model

// >>> rph_command_handler_tb.sv
`timescale 1ns/10ps
module rph_command_handler_tb;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic cmd_valid, cmd_port, cmd_write, cmd_pec_ok, rsp_valid, rsp_ack, reinit, out_en, digital, latched, ack;
	logic [7:0] cmd_code;
	logic [15:0] cmd_data, rsp_data, setpoint, rd;
	logic [15:0] prog_pin = 16'h6400;
	logic bus_act = 1'b1;
	logic ctl_pin = 1'b1;
	logic hl = 1'b1;
	logic ov = 1'b0;
	logic oc = 1'b0;
	logic uv = 1'b0;
	logic ot = 1'b0;
	logic ctl_port = 1'b0;
	logic [1:0] alert;
	int bad_count = 0;
	int total_checks = 0;
	always #20 mclk_in = ~mclk_in;
	rph_command_handler #(.RESTART_CYC(10), .WINDOW_CYC(200), .IDLE_CYC(50)) rph_command_handler_inst (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid), .cmd_port_in(cmd_port),
		.cmd_write_in(cmd_write), .cmd_code_in(cmd_code), .cmd_data_in(cmd_data), .cmd_pec_ok_in(cmd_pec_ok),
		.bus_activity_in(bus_act), .control_port_in(ctl_port), .rsp_valid_out(rsp_valid), .rsp_ack_out(rsp_ack),
		.rsp_data_out(rsp_data), .alert_out(alert), .i2c_reinit_out(reinit), .output_control_pin_in(ctl_pin),
		.high_line_setting_in(hl), .voltage_program_pin_in(prog_pin), .ov_fault_in(ov), .oc_fault_in(oc),
		.vin_uv_fault_in(uv), .temp_fault_in(ot), .output_enable_out(out_en), .vout_setpoint_out(setpoint),
		.digital_vout_out(digital), .latched_off_out(latched));
	rph_host_model rph_host_model_inst (.mclk_in(mclk_in), .rsp_ack_in(rsp_ack), .rsp_data_in(rsp_data),
		.cmd_valid_out(cmd_valid), .cmd_port_out(cmd_port), .cmd_write_out(cmd_write), .cmd_code_out(cmd_code),
		.cmd_data_out(cmd_data), .cmd_pec_ok_out(cmd_pec_ok));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic cmd(input logic p, input logic wr, input logic [7:0] c, input logic [15:0] d, input logic pec);
		rph_host_model_inst.xfer(p, wr, c, d, pec, ack, rd);
	endtask : cmd
	task automatic w(input logic [7:0] c, input logic [15:0] d);
		cmd(1'b0, 1'b1, c, d, 1'b1);
	endtask : w
	task automatic r(input logic [7:0] c);
		cmd(1'b0, 1'b0, c, 16'h0000, 1'b1);
	endtask : r
	task automatic t_power_up;
		check({15'h0, out_en}, 16'h0001);
		check(setpoint, prog_pin);
		r(8'h01);
		check(rd, 16'h0080);
		r(8'h10);
		check(rd, 16'h0000);
		r(8'h20);
		check(rd, 16'h0017);
		for (int i = 0; i < 2; i++) begin
			hl = i[0];
			r(8'h35);
			check(rd, i[0] ? 16'h0172 : 16'h00d2);
			r(8'h36);
			check(rd, i[0] ? 16'h0154 : 16'h00b4);
		end
	endtask : t_power_up
	task automatic t_faults;
		logic [7:0] hidden [3] = '{8'h02, 8'h19, 8'h98};
		for (int i = 0; i < 3; i++) begin
			r(hidden[i]);
			check({15'h0, ack}, 16'h0000);
		end
		check({14'h0, alert}, 16'h0001);
		cmd(1'b1, 1'b1, 8'h03, 16'h0000, 1'b1);
		check({15'h0, ack}, 16'h0001);
		check({14'h0, alert}, 16'h0001);
		w(8'h03, 16'h0000);
		check({14'h0, alert}, 16'h0000);
		cmd(1'b0, 1'b0, 8'h78, 16'h0000, 1'b0);
		check({15'h0, ack}, 16'h0000);
		r(8'h78);
		check(rd & 16'h0002, 16'h0002);
		w(8'h03, 16'h0000);
	endtask : t_faults
	task automatic t_vout;
		logic [15:0] val [4] = '{16'h7001, 16'h51ff, 16'h5200, 16'h7000};
		logic [15:0] exp [4] = '{16'h6600, 16'h6600, 16'h5200, 16'h7000};
		w(8'h21, 16'h6600);
		check({15'h0, digital}, 16'h0001);
		prog_pin = 16'h5800;
		repeat (3) @(negedge mclk_in);
		check(setpoint, 16'h6600);
		r(8'h21);
		check(rd, 16'h6600);
		for (int i = 0; i < 4; i++) begin
			w(8'h21, val[i]);
			check({15'h0, ack}, 16'h0001);
			check(setpoint, exp[i]);
		end
		r(8'h78);
		check(rd & 16'h0002, 16'h0002);
		w(8'h03, 16'h0000);
	endtask : t_vout
	task automatic t_lock;
		w(8'h10, 16'h0080);
		check({15'h0, ack}, 16'h0001);
		w(8'h01, 16'h0000);
		check({15'h0, ack}, 16'h0000);
		w(8'h10, 16'h0040);
		w(8'h01, 16'h0000);
		check({15'h0, ack}, 16'h0001);
		r(8'h78);
		check(rd & 16'h0040, 16'h0040);
		w(8'h21, 16'h6000);
		check({15'h0, ack}, 16'h0000);
		w(8'h01, 16'h0080);
		r(8'h78);
		check(rd & 16'h0040, 16'h0000);
		w(8'h10, 16'h0000);
		w(8'h42, 16'h6000);
		w(8'h21, 16'h6000);
		w(8'h14, 16'h0042);
		r(8'h42);
		check(rd, 16'h6c00);
		r(8'h21);
		check(rd, 16'h6000);
		w(8'h12, 16'h0000);
		r(8'h21);
		check(rd, 16'h6800);
		w(8'h03, 16'h0000);
	endtask : t_lock
	task automatic t_alarm;
		oc = 1'b1;
		repeat (2) @(negedge mclk_in);
		oc = 1'b0;
		r(8'h78);
		check(rd & 16'h0010, 16'h0010);
		w(8'h03, 16'h0000);
		r(8'h78);
		check(rd & 16'h0010, 16'h0000);
		oc = 1'b1;
		w(8'h03, 16'h0000);
		r(8'h78);
		check(rd & 16'h0010, 16'h0010);
		oc = 1'b0;
		w(8'h03, 16'h0000);
	endtask : t_alarm
	task automatic t_port;
		uv = 1'b1;
		ot = 1'b1;
		repeat (2) @(negedge mclk_in);
		uv = 1'b0;
		ot = 1'b0;
		r(8'h78);
		check(rd & 16'h000c, 16'h000c);
		ctl_port = 1'b1;
		repeat (2) @(negedge mclk_in);
		check({14'h0, alert}, 16'h0002);
		w(8'h03, 16'h0000);
		check({14'h0, alert}, 16'h0002);
		w(8'h21, 16'h6000);
		check({15'h0, ack}, 16'h0000);
		cmd(1'b1, 1'b1, 8'h03, 16'h0000, 1'b1);
		check({14'h0, alert}, 16'h0000);
		ctl_port = 1'b0;
		repeat (2) @(negedge mclk_in);
	endtask : t_port
	task automatic trip;
		ov = 1'b1;
		repeat (2) @(negedge mclk_in);
		ov = 1'b0;
		repeat (14) @(negedge mclk_in);
	endtask : trip
	task automatic t_ov;
		trip;
		trip;
		repeat (250) @(negedge mclk_in);
		trip;
		check({15'h0, latched}, 16'h0000);
		check({15'h0, out_en}, 16'h0001);
		for (int m = 0; m < 2; m++) begin
			repeat (250) @(negedge mclk_in);
			trip;
			trip;
			trip;
			check({15'h0, latched}, 16'h0001);
			if (m == 0) begin
				w(8'h01, 16'h0000);
				w(8'h01, 16'h0080);
				r(8'h78);
				check(rd & 16'h0020, 16'h0000);
			end else begin
				ctl_pin = 1'b0;
				repeat (3) @(negedge mclk_in);
				ctl_pin = 1'b1;
				repeat (3) @(negedge mclk_in);
			end
			check({15'h0, latched}, 16'h0000);
			check({15'h0, out_en}, 16'h0001);
		end
		bus_act = 1'b0;
		for (int n = 0; n < 80 && reinit !== 1'b1; n++) @(negedge mclk_in);
		check({15'h0, reinit}, 16'h0001);
		bus_act = 1'b1;
	endtask : t_ov
	task automatic test_done;
		if (bad_count == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done
	initial begin
		repeat (6) @(negedge mclk_in);
		rst_n_in = 1'b1;
		repeat (2) @(negedge mclk_in);
		t_power_up;
		t_faults;
		t_vout;
		t_lock;
		t_alarm;
		t_port;
		t_ov;
		test_done;
	end
	initial begin
		repeat (20000) @(posedge mclk_in);
		bad_count++;
		test_done;
	end
endmodule : rph_command_handler_tb
